//--- hw/periodic_frame_generator.sv
// periodic frame generator: stores injected setup frames in slots and replays them
// assumes the injection header is already parsed and the frame body sits in a buffer handle
//
// Function
// RULE1 - 1024 slots sharing eight period timers
// RULE2 - periods from 200 ns to minutes
// RULE3 - cpu picks slot via slot select field
// RULE4 - cpu picks timer 1 to 8
// RULE5 - timer period counted in 198.2 ns steps
// RULE6 - nonzero timer stores; zero means one-time
// RULE7 - setup frame bypassed, single destination port
// RULE8 - other header fields kept, egress rewriting applied
// RULE9 - resend when period passed since last send
// RULE10 - periodic frame beats other queued traffic
// RULE11 - frames due together go back-to-back
// RULE12 - spacing enabled: timer 8 separates frames
// RULE13 - cancel bit with slot number removes frame
// RULE14 - slots 0-15 any period, others above 30us
// RULE15 - sent frames counted with header qos
// RULE16 - bypass forwards straight to destination set
// RULE17 - cancel bit self-clears when removal done
// RULE18 - overwrite replaces slot and restarts period
`timescale 1ns/10ps
module periodic_frame_generator
	import pfg_pkg::*;
#(
	parameter int PORTS = DEF_PORTS
)
(
	input wire logic ref_clk_i,
	input wire logic rst_i,
	input wire logic inj_valid_i,
	input wire logic [SLOT_W-1:0] slot_select_field_i,
	input wire logic [TSEL_W-1:0] timer_select_field_i,
	input wire logic inj_bypass_i,
	input wire logic [PORTS-1:0] destination_port_set_i,
	input wire logic [QOS_W-1:0] inj_qos_i,
	input wire logic [HDR_W-1:0] inj_hdr_i,
	input wire logic [HANDLE_W-1:0] inj_handle_i,
	input wire logic [TIMERS*PERIOD_W-1:0] period_timer_config_i,
	input wire logic [PORTS-1:0] burst_spacing_enable_i,
	input wire logic [SLOT_W-1:0] cancel_slot_number_i,
	input wire logic cancel_trigger_bit_i,
	output logic cancel_trigger_bit_o,
	output logic norm_valid_o,
	output logic norm_analyze_o,
	output logic [PORTS-1:0] norm_destination_port_set_o,
	output logic [QOS_W-1:0] norm_qos_o,
	output logic [HDR_W-1:0] norm_hdr_o,
	output logic [HANDLE_W-1:0] norm_handle_o,
	input wire logic tx_ready_i,
	output logic tx_valid_o,
	output logic tx_priority_o,
	output logic tx_rewrite_o,
	output logic [PORTS-1:0] tx_destination_port_set_o,
	output logic [QOS_W-1:0] tx_qos_o,
	output logic [HDR_W-1:0] tx_hdr_o,
	output logic [HANDLE_W-1:0] tx_handle_o,
	output logic stat_inc_o,
	output logic [PORTS-1:0] stat_port_o,
	output logic [QOS_W-1:0] stat_qos_o
);
	// ==========================================================
	// slot memory
	logic [SLOTS-1:0] slot_used_q; // [RULE1]
	logic [HANDLE_W-1:0] slot_handle_q [SLOTS];
	logic [HDR_W-1:0] slot_hdr_q [SLOTS];
	logic [QOS_W-1:0] slot_qos_q [SLOTS];
	logic [TIDX_W-1:0] slot_timer_q [SLOTS];
	logic [PIDX_W-1:0] slot_port_q [SLOTS];
	logic [TICK_W-1:0] slot_last_q [SLOTS];
	logic [TICK_W-1:0] port_last_q [PORTS];
	logic [TICK_W-1:0] now;
	pfg_step_tick u_tick (
		.ref_clk_i(ref_clk_i),
		.rst_i(rst_i),
		.tick_o(),
		.now_o(now)
	);

	// ==========================================================
	// helpers
	function automatic logic [PIDX_W-1:0] port_index(input logic [PORTS-1:0] set);
		logic [PIDX_W-1:0] idx;
		idx = '0;
		for (int p = 0; p < PORTS; p++) begin
			if (set[p]) begin
				idx = PIDX_W'(p);
			end
		end
		return idx;
	endfunction : port_index

	// a zero period is read as one step so the slot cannot spin
	function automatic logic [PERIOD_W-1:0] period_of(input logic [TIDX_W-1:0] t);
		logic [PERIOD_W-1:0] per;
		per = period_timer_config_i[t*PERIOD_W +: PERIOD_W]; // [RULE5]
		if (per == '0) begin
			per = PERIOD_W'(1);
		end
		return per;
	endfunction : period_of

	function automatic logic elapsed(input logic [TICK_W-1:0] since, input logic [TIDX_W-1:0] t);
		logic [TICK_W-1:0] diff;
		diff = now - since; // [RULE2]
		return diff >= period_of(t);
	endfunction : elapsed

	// ==========================================================
	// control state
	logic pend_q, pend_d;
	logic [SLOT_W-1:0] pend_slot_q, pend_slot_d;
	logic [SLOT_W-1:0] slow_idx_q, slow_idx_d;
	logic cancel_busy_q, cancel_busy_d;
	logic [SLOT_W-1:0] cancel_slot_q, cancel_slot_d;
	logic [PORTS-1:0] tx_destination_port_set_q, tx_destination_port_set_d;
	logic [QOS_W-1:0] tx_qos_q, tx_qos_d;
	logic [HDR_W-1:0] tx_hdr_q, tx_hdr_d;
	logic [HANDLE_W-1:0] tx_handle_q, tx_handle_d;
	logic stat_q, stat_d;
	logic [PORTS-1:0] stat_port_q, stat_port_d;
	logic [QOS_W-1:0] stat_qos_q, stat_qos_d;
	logic norm_q, norm_d;
	logic norm_an_q, norm_an_d;
	logic [PORTS-1:0] norm_destination_port_set_q, norm_destination_port_set_d;
	logic [QOS_W-1:0] norm_qos_q, norm_qos_d;
	logic [HDR_W-1:0] norm_hdr_q, norm_hdr_d;
	logic [HANDLE_W-1:0] norm_handle_q, norm_handle_d;

	logic store_en, sent, cancel_done;
	logic fast_due, slow_due;
	logic [SLOT_W-1:0] fast_slot, pick_slot;
	function automatic logic slot_due(input logic [SLOT_W-1:0] s);
		logic ok;
		logic [PIDX_W-1:0] p;
		p = slot_port_q[s];
		ok = slot_used_q[s] && elapsed(slot_last_q[s], slot_timer_q[s]); // [RULE9]
		if (burst_spacing_enable_i[p] && !elapsed(port_last_q[p], SPACING_TIMER_IDX)) begin
			ok = 1'b0; // [RULE12]
		end
		if ((pend_q && pend_slot_q == s) || (cancel_done && cancel_slot_q == s)
			|| (store_en && slot_select_field_i == s)) begin
			ok = 1'b0; // [RULE13] [RULE18]
		end
		return ok;
	endfunction : slot_due

	// ==========================================================
	// injection, scanning and pending send
	// slots below 16 are checked every cycle, the rest once per 1024 cycles (20.48 us),
	// so only the low slots can hold periods shorter than the scan round
	always_comb begin
		store_en = inj_valid_i && timer_select_field_i != TSEL_ONE_TIME && inj_bypass_i; // [RULE6] [RULE7]
		sent = pend_q && tx_ready_i;
		cancel_done = cancel_busy_q;
		fast_due = 1'b0;
		fast_slot = '0;
		// lowest due low slot wins; heavy short-period use there delays the higher low slots
		for (int f = FAST_SLOTS-1; f >= 0; f--) begin
			if (slot_due(SLOT_W'(f))) begin
				fast_due = 1'b1; // [RULE14]
				fast_slot = SLOT_W'(f);
			end
		end
		slow_due = slot_due(slow_idx_q);
		pick_slot = fast_due ? fast_slot : slow_idx_q;
		slow_idx_d = slow_idx_q + SLOT_W'(1);
		// one-time injections pass straight on
		norm_d = inj_valid_i && timer_select_field_i == TSEL_ONE_TIME; // [RULE6]
		norm_an_d = !inj_bypass_i; // [RULE16]
		norm_destination_port_set_d = inj_bypass_i ? destination_port_set_i : '0; // [RULE16]
		norm_qos_d = inj_qos_i;
		norm_hdr_d = inj_hdr_i;
		norm_handle_d = inj_handle_i;

		pend_d = pend_q;
		pend_slot_d = pend_slot_q;
		tx_destination_port_set_d = tx_destination_port_set_q;
		tx_qos_d = tx_qos_q;
		tx_hdr_d = tx_hdr_q;
		tx_handle_d = tx_handle_q;
		if (sent) begin
			pend_d = 1'b0;
		end
		// a pending send is dropped if its slot is cancelled or rewritten before it leaves
		if (pend_q && !sent) begin
			if ((cancel_done && cancel_slot_q == pend_slot_q) || (store_en && slot_select_field_i == pend_slot_q)) begin
				pend_d = 1'b0; // [RULE13] [RULE18]
			end
		end
		// due frames are taken one after another, with one idle cycle between an accept and the next offer
		if (!pend_q && (fast_due || slow_due)) begin
			pend_d = 1'b1; // [RULE11]
			pend_slot_d = pick_slot;
			tx_destination_port_set_d = PORTS'(1) << slot_port_q[pick_slot];
			tx_qos_d = slot_qos_q[pick_slot];
			tx_hdr_d = slot_hdr_q[pick_slot]; // [RULE8]
			tx_handle_d = slot_handle_q[pick_slot];
		end
		stat_d = sent; // [RULE15]
		stat_port_d = tx_destination_port_set_q;
		stat_qos_d = tx_qos_q;
		// a new trigger in the completion cycle re-arms, so it is not lost
		cancel_busy_d = cancel_trigger_bit_i ? 1'b1 : 1'b0; // [RULE17]
		cancel_slot_d = cancel_trigger_bit_i ? cancel_slot_number_i : cancel_slot_q; // [RULE13]
	end

	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			pend_q <= 1'b0;
			pend_slot_q <= '0;
			slow_idx_q <= '0;
			cancel_busy_q <= 1'b0;
			cancel_slot_q <= '0;
			tx_destination_port_set_q <= '0;
			tx_qos_q <= '0;
			tx_hdr_q <= '0;
			tx_handle_q <= '0;
			stat_q <= 1'b0;
			stat_port_q <= '0;
			stat_qos_q <= '0;
			norm_q <= 1'b0;
			norm_an_q <= 1'b0;
			norm_destination_port_set_q <= '0;
			norm_qos_q <= '0;
			norm_hdr_q <= '0;
			norm_handle_q <= '0;
		end else begin
			pend_q <= pend_d;
			pend_slot_q <= pend_slot_d;
			slow_idx_q <= slow_idx_d;
			cancel_busy_q <= cancel_busy_d;
			cancel_slot_q <= cancel_slot_d;
			tx_destination_port_set_q <= tx_destination_port_set_d;
			tx_qos_q <= tx_qos_d;
			tx_hdr_q <= tx_hdr_d;
			tx_handle_q <= tx_handle_d;
			stat_q <= stat_d;
			stat_port_q <= stat_port_d;
			stat_qos_q <= stat_qos_d;
			norm_q <= norm_d;
			norm_an_q <= norm_an_d;
			norm_destination_port_set_q <= norm_destination_port_set_d;
			norm_qos_q <= norm_qos_d;
			norm_hdr_q <= norm_hdr_d;
			norm_handle_q <= norm_handle_d;
		end
	end

	// ==========================================================
	// slot memory writes; a fresh store wins over a cancel of the same slot
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			slot_used_q <= '0;
			for (int p = 0; p < PORTS; p++) begin
				port_last_q[p] <= '0;
			end
		end else begin
			if (cancel_done) begin
				slot_used_q[cancel_slot_q] <= 1'b0; // [RULE13]
			end
			if (sent) begin
				slot_last_q[pend_slot_q] <= now; // [RULE9]
				port_last_q[port_index(tx_destination_port_set_q)] <= now; // [RULE12]
			end
			if (store_en) begin
				slot_used_q[slot_select_field_i] <= 1'b1; // [RULE3] [RULE18]
				slot_handle_q[slot_select_field_i] <= inj_handle_i;
				slot_hdr_q[slot_select_field_i] <= inj_hdr_i; // [RULE8]
				slot_qos_q[slot_select_field_i] <= inj_qos_i; // [RULE15]
				slot_timer_q[slot_select_field_i] <= TIDX_W'(timer_select_field_i - TSEL_W'(1)); // [RULE4]
				slot_port_q[slot_select_field_i] <= port_index(destination_port_set_i); // [RULE7]
				slot_last_q[slot_select_field_i] <= now; // [RULE18]
			end
		end
	end

	// ==========================================================
	// outputs
	assign cancel_trigger_bit_o = cancel_busy_q; // [RULE17]
	assign tx_valid_o = pend_q;
	assign tx_priority_o = pend_q; // [RULE10]
	assign tx_rewrite_o = pend_q; // [RULE8]
	assign tx_destination_port_set_o = tx_destination_port_set_q;
	assign tx_qos_o = tx_qos_q;
	assign tx_hdr_o = tx_hdr_q;
	assign tx_handle_o = tx_handle_q;
	assign stat_inc_o = stat_q;
	assign stat_port_o = stat_port_q;
	assign stat_qos_o = stat_qos_q;
	assign norm_valid_o = norm_q;
	assign norm_analyze_o = norm_an_q;
	assign norm_destination_port_set_o = norm_destination_port_set_q;
	assign norm_qos_o = norm_qos_q;
	assign norm_hdr_o = norm_hdr_q;
	assign norm_handle_o = norm_handle_q;
endmodule : periodic_frame_generator

//--- pkg/pfg_pkg.sv
// constants shared by the periodic frame generator and its step tick generator
// assumes a single switch core clock at 50 MHz
package pfg_pkg;
	// ==========================================================
	// slot and timer geometry
	localparam int SLOTS = 1024;
	localparam int SLOT_W = 10;
	localparam int FAST_SLOTS = 16;
	localparam int FAST_W = 4;
	localparam int TIMERS = 8;
	localparam int TSEL_W = 4;
	localparam int TIDX_W = 3;
	localparam logic [TIDX_W-1:0] SPACING_TIMER_IDX = 3'h7;
	localparam logic [TSEL_W-1:0] TSEL_ONE_TIME = 4'h0;
	// ==========================================================
	// field widths
	localparam int PERIOD_W = 32;
	localparam int TICK_W = 32;
	localparam int QOS_W = 3;
	localparam int HDR_W = 32;
	localparam int HANDLE_W = 16;
	localparam int DEF_PORTS = 4;
	localparam int PIDX_W = 2;
	// ==========================================================
	// timing: one period step and the core clock period, both in picoseconds
	localparam int STEP_PS = 198200;
	localparam int CLK_PS = 20000;
	localparam int MIN_PERIOD_NS = 200;
	localparam int ACC_W = 18;
	localparam logic [ACC_W-1:0] STEP_ACC = ACC_W'(STEP_PS);
	localparam logic [ACC_W-1:0] CLK_ACC = ACC_W'(CLK_PS);
endpackage : pfg_pkg

//--- hw/pfg_step_tick.sv
// step tick generator: one pulse per period step, plus a running step count
// assumes a free running core clock; the step is not a whole number of cycles
`timescale 1ns/10ps
module pfg_step_tick
	import pfg_pkg::*;
(
	input wire logic ref_clk_i,
	input wire logic rst_i,
	output logic tick_o,
	output logic [TICK_W-1:0] now_o
);
	logic [ACC_W-1:0] acc_q, acc_d;
	logic [TICK_W-1:0] now_q, now_d;
	logic tick_q, tick_d;

	// ==========================================================
	// fractional accumulator
	// a plain divider would drift; the accumulator keeps the long term rate exact
	always_comb begin
		acc_d = acc_q + CLK_ACC;
		tick_d = 1'b0;
		now_d = now_q;
		if (acc_d >= STEP_ACC) begin
			acc_d = acc_d - STEP_ACC;
			tick_d = 1'b1;
			now_d = now_q + TICK_W'(1);
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			acc_q <= '0;
			now_q <= '0;
			tick_q <= 1'b0;
		end else begin
			acc_q <= acc_d;
			now_q <= now_d;
			tick_q <= tick_d;
		end
	end

	assign tick_o = tick_q;
	assign now_o = now_q;
endmodule : pfg_step_tick

//--- dv/pfg_chk.sv
// port assertions for the periodic frame generator
// assumes it is bound into periodic_frame_generator and sees its ports only
`timescale 1ns/10ps
module pfg_chk
	import pfg_pkg::*;
#(
	parameter int PORTS = DEF_PORTS
)
(
	input wire logic ref_clk_i,
	input wire logic rst_i,
	input wire logic inj_valid_i,
	input wire logic [TSEL_W-1:0] timer_select_field_i,
	input wire logic inj_bypass_i,
	input wire logic [PORTS-1:0] destination_port_set_i,
	input wire logic cancel_trigger_bit_i,
	input wire logic cancel_trigger_bit_o,
	input wire logic norm_valid_o,
	input wire logic norm_analyze_o,
	input wire logic [PORTS-1:0] norm_destination_port_set_o,
	input wire logic tx_ready_i,
	input wire logic tx_valid_o,
	input wire logic tx_priority_o,
	input wire logic tx_rewrite_o,
	input wire logic [PORTS-1:0] tx_destination_port_set_o,
	input wire logic [QOS_W-1:0] tx_qos_o,
	input wire logic [HANDLE_W-1:0] tx_handle_o,
	input wire logic stat_inc_o,
	input wire logic [PORTS-1:0] stat_port_o,
	input wire logic [QOS_W-1:0] stat_qos_o
);
	// ==========================================================
	// properties
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (rst_i);
	sequence s_take;
		tx_valid_o && tx_ready_i;
	endsequence
	sequence s_once;
		inj_valid_i && timer_select_field_i == TSEL_ONE_TIME;
	endsequence
	a_cancel_start: assert property (cancel_trigger_bit_i |=> cancel_trigger_bit_o)
		else $error("cancel bit not raised");
	a_cancel_clear: assert property (cancel_trigger_bit_o && !cancel_trigger_bit_i |=> !cancel_trigger_bit_o)
		else $error("cancel bit did not clear");
	a_once_fwd: assert property (s_once |=> norm_valid_o)
		else $error("one-time frame not forwarded");
	a_bypass_destination_port_set: assert property (s_once ##0 inj_bypass_i |=> !norm_analyze_o && norm_destination_port_set_o == $past(destination_port_set_i))
		else $error("bypass frame not sent direct");
	// cancel and overwrite may withdraw an offer, so they are left out here
	a_tx_hold: assert property (tx_valid_o && !tx_ready_i && !cancel_trigger_bit_o && !cancel_trigger_bit_i
		&& !inj_valid_i |=> tx_valid_o && $stable(tx_handle_o) && $stable(tx_destination_port_set_o))
		else $error("offer dropped before accept");
	a_tx_flags: assert property (tx_priority_o == tx_valid_o && tx_rewrite_o == tx_valid_o)
		else $error("priority or rewrite flag wrong");
	a_tx_port: assert property (tx_valid_o |-> $onehot(tx_destination_port_set_o))
		else $error("offer not on one port");
	a_stat_count: assert property (s_take |=> stat_inc_o && stat_port_o == $past(tx_destination_port_set_o) && stat_qos_o == $past(tx_qos_o))
		else $error("statistics pulse wrong");
	a_stat_only: assert property (!(tx_valid_o && tx_ready_i) |=> !stat_inc_o)
		else $error("statistics without send");
	a_offer_gap: assert property (s_take |=> !tx_valid_o)
		else $error("offer right after accept");
endmodule : pfg_chk
bind periodic_frame_generator pfg_chk #(.PORTS(PORTS)) chk (.*);

//--- dv/pfg_egress_model.sv
// egress port model: takes periodic offers, after any frame still on the wire
// assumes the core clock is shared with the generator
`timescale 1ns/10ps
module pfg_egress_model (
	input wire logic ref_clk_i,
	input wire logic rst_i,
	input wire logic tx_valid_i,
	input wire logic [3:0] busy_i,
	output logic tx_ready_o
);
	// ==========================================================
	// frame in flight; busy_i of 0 gives a prompt port
	logic [3:0] left_q;
	assign tx_ready_o = tx_valid_i && left_q == 4'h0;
	always_ff @(posedge ref_clk_i) begin
		if (rst_i)
			left_q <= 4'h0;
		else if (tx_ready_o)
			left_q <= busy_i;
		else if (left_q != 4'h0)
			left_q <= left_q - 4'h1;
	end
endmodule : pfg_egress_model

//--- dv/periodic_frame_generator_tb_top.sv
// self-checking bench for the periodic frame generator
// assumes pfg_pkg, the checker and the egress model are compiled first
`timescale 1ns/10ps
module periodic_frame_generator_tb_top;
	import pfg_pkg::*;
	typedef struct {logic [3:0] dst; logic [QOS_W-1:0] qos; logic [HDR_W-1:0] hdr; int per; real last; int n; real slk;} ent_t;
	logic ref_clk_i = 0, rst_i = 1, inj_valid_i = 0, inj_bypass_i = 0, cancel_trigger_bit_i = 0, tx_ready_i;
	logic [SLOT_W-1:0] slot_select_field_i = 0, cancel_slot_number_i = 0;
	logic [TSEL_W-1:0] timer_select_field_i = 0;
	logic [3:0] destination_port_set_i = 0, burst_spacing_enable_i = 0, norm_destination_port_set_o, tx_destination_port_set_o, stat_port_o, busy = 0;
	logic [QOS_W-1:0] inj_qos_i = 0, norm_qos_o, tx_qos_o, stat_qos_o;
	logic [HDR_W-1:0] inj_hdr_i = 0, norm_hdr_o, tx_hdr_o;
	logic [HANDLE_W-1:0] inj_handle_i = 0, norm_handle_o, tx_handle_o, h, h0, h1;
	logic [TIMERS*PERIOD_W-1:0] period_timer_config_i = 0;
	logic cancel_trigger_bit_o, norm_valid_o, norm_analyze_o, tx_valid_o, tx_priority_o, tx_rewrite_o, stat_inc_o;
	int bad_count = 0, checked = 0, cyc = 0;
	int tp[8] = '{3, 160, 30, 4, 5, 6, 7, 10};
	real sp_last = 0;
	ent_t tbl [logic [HANDLE_W-1:0]];
	logic [HDR_W+HANDLE_W+QOS_W+4:0] norm_q [$];
	periodic_frame_generator dut (.*);
	pfg_egress_model egress (.ref_clk_i, .rst_i, .tx_valid_i(tx_valid_o), .busy_i(busy), .tx_ready_o(tx_ready_i));
	always #10 ref_clk_i = ~ref_clk_i;
	// ==========================================================
	// compare and report
	task automatic chk(input bit ok, input string m);
		checked++;
		if (!ok) begin
			bad_count++;
			$display("unexpected at %0t: %s", $time, m);
		end
	endtask : chk
	task automatic chk_norm;
		chk(norm_q.size() > 0 && norm_q.pop_front() === {norm_analyze_o, norm_destination_port_set_o, norm_qos_o, norm_hdr_o,
			norm_handle_o}, "one-time frame");
	endtask : chk_norm
	// bounds allow one step of quantisation, slow scans and queueing
	task automatic chk_tx;
		real t;
		ent_t e;
		t = $realtime;
		chk(tbl.exists(tx_handle_o), "frame from empty slot");
		if (tbl.exists(tx_handle_o)) begin
			e = tbl[tx_handle_o];
			chk({tx_destination_port_set_o, tx_qos_o, tx_hdr_o} === {e.dst, e.qos, e.hdr}, "periodic fields");
			chk(t - e.last >= (e.per - 1) * 198.2 && t - e.last <= (e.per + 1) * 198.2 + e.slk, "period");
			tbl[tx_handle_o].last = t;
			tbl[tx_handle_o].n++;
		end
		if (tx_destination_port_set_o === 4'h2 && sp_last > 0)
			chk(t - sp_last >= 9 * 198.2, "spacing");
		if (tx_destination_port_set_o === 4'h2)
			sp_last = t;
	endtask : chk_tx
	task automatic tally_and_finish;
		$display("comparisons %0d mismatches %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : tally_and_finish
	always @(posedge ref_clk_i) begin
		if (norm_valid_o === 1'b1)
			chk_norm();
		if (tx_valid_o === 1'b1 && tx_ready_i === 1'b1)
			chk_tx();
	end
	always @(posedge ref_clk_i) begin
		cyc++;
		if (cyc == 20000) begin
			bad_count++;
			tally_and_finish();
		end
	end
	// ==========================================================
	// stimulus
	task automatic inject(input int s, input int k, input bit byp, input logic [3:0] d, input real slk,
		output logic [HANDLE_W-1:0] hh);
		@(posedge ref_clk_i);
		inj_valid_i <= 1'b1;
		slot_select_field_i <= s[SLOT_W-1:0];
		timer_select_field_i <= k[TSEL_W-1:0];
		inj_bypass_i <= byp;
		destination_port_set_i <= d;
		inj_qos_i <= QOS_W'($urandom);
		inj_hdr_i <= $urandom;
		inj_handle_i <= HANDLE_W'($urandom);
		@(posedge ref_clk_i);
		inj_valid_i <= 1'b0;
		hh = inj_handle_i;
		if (k == 0)
			norm_q.push_back({~byp, byp ? d : 4'h0, inj_qos_i, inj_hdr_i, inj_handle_i});
		else if (byp)
			tbl[hh] = '{d, inj_qos_i, inj_hdr_i, tp[k-1], $realtime, 0, slk};
	endtask : inject
	initial begin
		void'($urandom(32'hA1DD44ED));
		for (int k = 0; k < 8; k++)
			period_timer_config_i[k*PERIOD_W +: PERIOD_W] <= tp[k];
		repeat (12) @(posedge ref_clk_i);
		rst_i <= 1'b0;
		burst_spacing_enable_i <= 4'h2;
		for (int i = 0; i < 12; i++)
			inject($urandom % 1024, 0, i % 2, 4'h1 << (i % 4), 0, h);
		inject(9, 1, 0, 4'h1, 0, h);
		inject(3, 1, 1, 4'h1, 600, h0);
		inject(700, 2, 1, 4'h4, 4 * 20480 + 600, h1);
		inject(5, 3, 1, 4'h2, 600, h);
		inject(6, 3, 1, 4'h2, 12 * 198.2 + 600, h);
		inject(7, 3, 1, 4'h1, 600, h);
		inject(8, 3, 1, 4'h1, 600, h);
		repeat (4000) @(posedge ref_clk_i);
		busy <= 4'h5;
		repeat (4000) @(posedge ref_clk_i);
		foreach (tbl[x])
			chk(tbl[x].n > 0, "slot never sent");
		inject(3, 4, 1, 4'h8, 600, h);
		repeat (2) @(posedge ref_clk_i);
		tbl.delete(h0);
		cancel_slot_number_i <= 10'h2BC;
		cancel_trigger_bit_i <= 1'b1;
		@(posedge ref_clk_i);
		cancel_trigger_bit_i <= 1'b0;
		repeat (3) @(posedge ref_clk_i);
		tbl.delete(h1);
		repeat (4000) @(posedge ref_clk_i);
		foreach (tbl[x])
			chk(tbl[x].n > 0, "slot never sent");
		tally_and_finish();
	end
endmodule : periodic_frame_generator_tb_top
